// *** design/iars_dev.sv ***
// Processor end: reset, initialization and interrupt acknowledge.
// Notes on behaviour
// - Controller holds request until first acknowledge
// - Acknowledge starts only at interruptible point
// - Acknowledge valid through address, data, waits
// - Five idle cycles, then vector read
// - Both acknowledges drive fixed address
// - Controller ends each cycle with ready
// - Higher priority serviced, else vector posted
// - Typical response within five microseconds
// - Self message delivered internally, no bus
// - Synchronous inputs: one cycle low, high
// - Asynchronous inputs synchronized; two cycles each
// - Reset aborts activity, outputs inactive
// - After reset, initialize then fetch fixed address
// - Reset held at least 41 clocks
// - Edge after release starts bus phase
// - User reset passes two flip-flops
// - Interrupt zero strap picks processor role
// - Bad-access strap enables initialization
// - Single processor strapped as primary
// - Fault held through self-test, kept on failure
// - Checksum eight words; mismatch faults and halts
// - Latched interrupts cleared before first instruction
// - Zero line-two vector selects controller mode
// Assumes reset comes from the controller end's reset output.
`timescale 1ns/1ps
module iars_dev import iars_pkg::*; (
  // System
  input wire logic clock,
  input wire logic reset,
  // Link
  iars_if.dev link,
  // Configuration and core status
  input wire logic [7:0] vec0_field,
  input wire logic [7:0] vec2_field,
  input wire logic [4:0] cur_priority,
  input wire logic cpu_busy,
  input wire logic selftest_fail,
  // Interrupt requests
  input wire logic self_msg,
  input wire logic [3:0] irq_clear,
  output logic [3:0] irq_pending,
  output logic agent_message_pending,
  // Vector delivery
  output logic service_now,
  output logic post_vector,
  output logic [7:0] vector,
  // Init results and late-response flag
  output logic fetch_start,
  output logic [31:0] fetch_addr,
  output logic [31:0] boot_ptr,
  output iars_role_e role,
  output logic init_enable,
  output logic halted,
  output logic late_response
);
  iars_state_e state;
  logic ph;
  logic rst_d;
  logic [4:0] s1;
  logic [4:0] s2;
  logic [3:0] act_d;
  logic [7:0] cnt;
  logic [31:0] sum;
  logic aph;
  logic cyc;
  logic fault;
  logic [31:0] addr;
  logic posted;
  logic [7:0] posted_vec;
  logic [15:0] lat_cnt;

  // Decode of mode fields and synced lines
  wire ext_mode = vec2_field == 8'h00;
  wire msg_mode = vec0_field == 8'h00;
  wire [3:0] act = {~s2[3], s2[2], s2[1], ~s2[0]};
  wire [3:0] rise = act & ~act_d;
  wire [3:0] use_mask = {~ext_mode, ~ext_mode, 1'b1, ~msg_mode};
  wire ext_req = ext_mode & s2[2];
  wire pe = ph;
  wire bus_end = pe & cyc & ~aph & link.bus_ready;
  wire [31:0] new_sum = sum + link.bus_rdata;
  wire [4:0] vec_prio = link.bus_rdata[7:3];
  wire [4:0] post_prio = posted_vec[7:3];
  wire start_ack = state == ST_RUN && pe && ext_req && !cpu_busy;

  always_ff @(posedge clock) begin
    s1 <= {link.bad_access_in, link.irq_line_three,
      link.irq2_or_ext_request, link.irq_line_one,
      link.irq0_or_msg_in};
    s2 <= s1;
  end

  // phase starts at first edge after release
  always_ff @(posedge clock) begin
    if (reset) begin
      ph <= 1'b0;
    end else begin
      ph <= ~ph;
    end
  end

  always_ff @(posedge clock) begin
    rst_d <= reset;
    if (reset) begin
      role <= ROLE_PRIMARY;
      init_enable <= 1'b0;
    end else if (rst_d) begin
      role <= s2[0] ? ROLE_PRIMARY : ROLE_SECONDARY;
      init_enable <= s2[4];
    end
  end

  // hardware clear before first fetch
  // Set wins over software clear so no edge is lost
  always_ff @(posedge clock) begin
    if (reset || state == ST_CLEAR) begin
      irq_pending <= 4'h0;
      agent_message_pending <= 1'b0;
      act_d <= 4'hf;
    end else begin
      act_d <= act;
      irq_pending <= (irq_pending & ~irq_clear) | (rise & use_mask);
      agent_message_pending <= (agent_message_pending & ~irq_clear[0])
        | self_msg | (rise[0] & msg_mode);
    end
  end

  // flag a response slower than typical
  always_ff @(posedge clock) begin
    if (reset) begin
      lat_cnt <= 16'h0000;
      late_response <= 1'b0;
    end else if (ext_req && state == ST_RUN) begin
      lat_cnt <= lat_cnt + 16'h0001;
      if (lat_cnt >= 16'(`IARS_LAT_CYC)) begin
        late_response <= 1'b1;
      end
    end else begin
      lat_cnt <= 16'h0000;
    end
  end

  // Sequencer; steps move on the processor-cycle enable, except ST_CLEAR, ST_HALT and posted service in ST_RUN
  // reset drops all activity
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= ST_FAULT_WAIT;
      cnt <= 8'h00;
      sum <= 32'h0000_0000;
      aph <= 1'b0;
      cyc <= 1'b0;
      fault <= 1'b0;
      addr <= 32'h0000_0000;
      posted <= 1'b0;
      posted_vec <= 8'h00;
      vector <= 8'h00;
      service_now <= 1'b0;
      post_vector <= 1'b0;
      fetch_start <= 1'b0;
      fetch_addr <= 32'h0000_0000;
      boot_ptr <= 32'h0000_0000;
      halted <= 1'b0;
    end else begin
      service_now <= 1'b0;
      post_vector <= 1'b0;
      fetch_start <= 1'b0;
      if (pe && cyc && aph) begin
        aph <= 1'b0;
      end
      case (state)
        ST_FAULT_WAIT: if (pe) begin
          cnt <= cnt + 8'h01;
          // fault a few cycles after release
          if (cnt == `IARS_FAULT_DLY) begin
            fault <= 1'b1;
            cnt <= 8'h00;
            state <= ST_SELFTEST;
          end
        end
        ST_SELFTEST: if (pe) begin
          cnt <= cnt + 8'h01;
          if (cnt == `IARS_SELFTEST_CYC) begin
            cnt <= 8'h00;
            if (selftest_fail) begin
              state <= ST_HALT;
            end else if (init_enable) begin
              fault <= 1'b0;
              addr <= `IARS_CKSUM_BASE;
              cyc <= 1'b1;
              aph <= 1'b1;
              sum <= 32'h0000_0000;
              state <= ST_CKSUM;
            end else begin
              fault <= 1'b0;
              state <= ST_CLEAR;
            end
          end
        end
        ST_CKSUM: if (bus_end) begin
          sum <= new_sum;
          cnt <= cnt + 8'h01;
          cyc <= 1'b0;
          if (cnt == 8'h00) begin
            boot_ptr <= link.bus_rdata;
          end
          if (cnt == `IARS_CKSUM_WORDS - 8'h01) begin
            if (new_sum == `IARS_CKSUM_GOOD) begin
              state <= ST_CLEAR;
            end else begin
              fault <= 1'b1;
              state <= ST_HALT;
            end
          end else begin
            addr <= addr + 32'h0000_0004;
          end
        end else if (pe && !cyc) begin
          // One idle processor cycle lets the controller drop ready
          cyc <= 1'b1;
          aph <= 1'b1;
        end
        ST_CLEAR: begin
          fetch_start <= 1'b1;
          fetch_addr <= `IARS_START_ADDR;
          state <= ST_RUN;
        end
        ST_RUN: begin
          if (start_ack) begin
            addr <= `IARS_ACK_ADDR;
            cyc <= 1'b1;
            aph <= 1'b1;
            state <= ST_ACK1;
          end else if (posted && post_prio > cur_priority) begin
            service_now <= 1'b1;
            vector <= posted_vec;
            posted <= 1'b0;
          end
        end
        ST_ACK1: if (bus_end) begin
          cyc <= 1'b0;
          cnt <= 8'h00;
          state <= ST_IDLE;
        end
        ST_IDLE: if (pe) begin
          cnt <= cnt + 8'h01;
          if (cnt == `IARS_IDLE_CYC - 8'h01) begin
            addr <= `IARS_ACK_ADDR;
            cyc <= 1'b1;
            aph <= 1'b1;
            cnt <= 8'h00;
            state <= ST_ACK2;
          end
        end
        ST_ACK2: if (bus_end) begin
          cyc <= 1'b0;
          vector <= link.bus_rdata[7:0];
          state <= ST_RUN;
          // service now or post to table
          if (vec_prio > cur_priority) begin
            service_now <= 1'b1;
          end else begin
            post_vector <= 1'b1;
            posted <= 1'b1;
            posted_vec <= link.bus_rdata[7:0];
          end
        end
        ST_HALT: begin
          cyc <= 1'b0;
          aph <= 1'b0;
          halted <= 1'b1;
        end
        default: state <= ST_HALT;
      endcase
    end
  end

  // acknowledge spans the whole bus cycle
  assign link.irq_ack_oe = cyc & (state == ST_ACK1 || state == ST_ACK2);
  assign link.init_fault_oe = fault;
  assign link.bus_cycle = cyc;
  assign link.bus_addr_phase = cyc & aph;
  assign link.bus_addr = addr;
endmodule

// *** design/iars_map.svh ***
// Constants for the interrupt-acknowledge, reset and init sequencer.
// Included by the package; holds definitions only.
`ifndef IARS_MAP_SVH
`define IARS_MAP_SVH
// Clock period of the system clock in ns
`define IARS_CLK_NS 20
// Fixed address driven in both acknowledge cycles
`define IARS_ACK_ADDR 32'hffff_fffc
// Idle processor cycles between the two acknowledges
`define IARS_IDLE_CYC 8'h05
// Words summed by the startup checksum, and their base
`define IARS_CKSUM_WORDS 8'h08
`define IARS_CKSUM_BASE 32'h0000_0000
// Sum of the checksum words that counts as good
`define IARS_CKSUM_GOOD 32'h0000_0000
// First fetch address after initialization
`define IARS_START_ADDR 32'h0000_0000
// Processor cycles from reset release to fault assertion
`define IARS_FAULT_DLY 8'h03
// Processor cycles spent in self-test
`define IARS_SELFTEST_CYC 8'h10
// Typical response time in ns and its count in clocks
`define IARS_LAT_NS 5000
`define IARS_LAT_CYC (`IARS_LAT_NS / `IARS_CLK_NS)
// Least reset length, in clock cycles
`define IARS_RESET_MIN 8'h29
// Wait states the controller inserts per acknowledge
`define IARS_WAIT_STATES 8'h04
`endif

// *** design/iars_pkg.sv ***
// Types shared by both ends of the interrupt/reset link.
// Assumes iars_map.svh is on the include path.
`include "iars_map.svh"
package iars_pkg;
  // Role chosen by the processor-number strap
  typedef enum logic {ROLE_PRIMARY, ROLE_SECONDARY} iars_role_e;
  // Sequencer states of the device end
  typedef enum logic [3:0] {
    ST_FAULT_WAIT, ST_SELFTEST, ST_CKSUM, ST_CLEAR, ST_RUN,
    ST_ACK1, ST_IDLE, ST_ACK2, ST_HALT
  } iars_state_e;
endpackage

// *** design/iars_if.sv ***
// Link between the processor end and the controller/reset end.
// Resolves the three open-drain wire levels from their enables.
`timescale 1ns/1ps
interface iars_if;
  // Pins the controller end drives
  logic proc_reset;
  logic irq0_or_msg_in;
  logic irq_line_one;
  logic irq2_or_ext_request;
  logic irq3_drive;
  logic bad_access_in;
  logic bus_ready;
  logic [31:0] bus_rdata;
  // Pins the processor end drives
  logic irq_ack_oe;
  logic init_fault_oe;
  logic bus_cycle;
  logic bus_addr_phase;
  logic [31:0] bus_addr;
  // Open-drain wire levels, low while pulled
  logic irq_line_three;
  logic irq_ack_n;
  logic init_fault_n;
  assign irq_ack_n = ~irq_ack_oe;
  assign irq_line_three = irq3_drive & ~irq_ack_oe;
  assign init_fault_n = ~init_fault_oe;
  modport dev (
    input proc_reset, irq0_or_msg_in, irq_line_one,
    input irq2_or_ext_request, irq_line_three, bad_access_in,
    input bus_ready, bus_rdata,
    output irq_ack_oe, init_fault_oe, bus_cycle, bus_addr_phase,
    output bus_addr
  );
  modport ctl (
    output proc_reset, irq0_or_msg_in, irq_line_one,
    output irq2_or_ext_request, irq3_drive, bad_access_in,
    output bus_ready, bus_rdata,
    input irq_ack_n, init_fault_n, bus_cycle, bus_addr_phase,
    input bus_addr
  );
endinterface

// *** design/iars_ctrl.sv ***
// Controller end: interrupt controller and reset generation.
// Assumes the testbench feeds link.proc_reset to the device reset.
`timescale 1ns/1ps
module iars_ctrl import iars_pkg::*; (
  // System
  input wire logic clock,
  input wire logic reset,
  // Link
  iars_if.ctl link,
  // User side
  input wire logic user_reset_n,
  input wire logic strap_primary,
  input wire logic strap_init,
  input wire logic raise_request,
  input wire logic [7:0] request_vector,
  input wire logic irq0_n,
  input wire logic irq1,
  input wire logic irq3_n,
  input wire logic bad_access,
  input wire logic [31:0] mem_rdata
);
  logic rst_s1;
  logic rst_s2;
  logic [7:0] rst_cnt;
  logic proc_reset;
  logic req;
  logic second;
  logic [7:0] wait_cnt;
  logic ready;
  logic [31:0] rdata;
  logic ack_prev;
  wire ack_now = ~link.irq_ack_n;
  wire ack_cyc = link.bus_addr == `IARS_ACK_ADDR;
  wire ack_rise = ack_now & ~ack_prev;
  wire ack_fall = ~ack_now & ack_prev;
  wire cyc_data = link.bus_cycle & ~link.bus_addr_phase;
  wire wait_done = wait_cnt >= (`IARS_WAIT_STATES << 1);

  always_ff @(posedge clock) begin
    rst_s1 <= ~user_reset_n;
    rst_s2 <= rst_s1;
  end

  always_ff @(posedge clock) begin
    if (reset || rst_s2) begin
      rst_cnt <= 8'h00;
      proc_reset <= 1'b1;
    end else if (rst_cnt < `IARS_RESET_MIN) begin
      rst_cnt <= rst_cnt + 8'h01;
    end else begin
      proc_reset <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      req <= 1'b0;
      ack_prev <= 1'b0;
    end else begin
      ack_prev <= ack_now;
      if (ack_rise) begin
        req <= 1'b0;
      end else if (raise_request) begin
        req <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset || !link.bus_cycle) begin
      wait_cnt <= 8'h00;
      ready <= 1'b0;
    end else if (cyc_data) begin
      if (!ack_cyc || wait_done) begin
        ready <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 8'h01;
      end
    end
  end

  // Vector only on the second acknowledge
  // Toggled by the end of each acknowledge, so the two-clock
  // address phase cannot flip it twice
  always_ff @(posedge clock) begin
    if (reset || proc_reset) begin
      second <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      if (ack_fall) begin
        second <= ~second;
      end
      if (!ack_cyc) begin
        rdata <= mem_rdata;
      end else if (second) begin
        rdata <= {24'h00_0000, request_vector};
      end else begin
        rdata <= 32'h0000_0000;
      end
    end
  end

  // straps driven while reset is held
  assign link.proc_reset = proc_reset;
  assign link.irq0_or_msg_in = proc_reset ? strap_primary : irq0_n;
  assign link.bad_access_in = proc_reset ? strap_init : bad_access;
  // lines driven straight from user inputs and clocked logic
  assign link.irq_line_one = irq1;
  assign link.irq2_or_ext_request = req;
  assign link.irq3_drive = irq3_n;
  assign link.bus_ready = ready;
  assign link.bus_rdata = rdata;
endmodule

// *** verif/iars_assertions.sv ***
// Concurrent checks on the processor/controller link.
// Expects the link's signals plus the system clock and reset.
`timescale 1ns/1ps
`include "iars_map.svh"
module iars_assertions (
  // System
  input wire logic clock,
  input wire logic reset,
  // Link
  input wire logic proc_reset,
  input wire logic irq2_or_ext_request,
  input wire logic irq_ack_oe,
  input wire logic init_fault_oe,
  input wire logic bus_cycle,
  input wire logic bus_addr_phase,
  input wire logic [31:0] bus_addr,
  input wire logic bus_ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic ack_second;
  // Tells the first acknowledge from the second
  always_ff @(posedge clock) begin
    if (reset || proc_reset) ack_second <= 1'b0;
    else if ($fell(irq_ack_oe)) ack_second <= ~ack_second;
  end
  a_ack_addr: assert property (
    $rose(irq_ack_oe) |-> bus_addr_phase && bus_addr == `IARS_ACK_ADDR)
    else $error("acknowledge without fixed address");
  a_ack_after_cycle: assert property (
    $rose(irq_ack_oe) |-> !$past(bus_cycle))
    else $error("acknowledge cut into a bus cycle");
  a_ack_in_cycle: assert property (
    irq_ack_oe |-> bus_cycle) else $error("acknowledge outside a cycle");
  a_ack_holds: assert property (
    irq_ack_oe && !bus_ready && !proc_reset |=>
      irq_ack_oe && $stable(bus_addr))
    else $error("acknowledge dropped before ready");
  // Ack one falls, at least four idle cycles pass, then ack two
  a_idle_gap: assert property (
    $fell(irq_ack_oe) && !ack_second |->
      (!irq_ack_oe && !bus_cycle)[*8] ##[2:4] irq_ack_oe)
    else $error("idle gap between acknowledges wrong");
  a_reset_quiet: assert property (
    proc_reset |=> !irq_ack_oe && !bus_cycle && !init_fault_oe)
    else $error("output active during reset");
  a_fault_rise: assert property (
    $fell(proc_reset) |-> ##[1:12] init_fault_oe)
    else $error("fault not raised after reset");
  a_fault_holds: assert property (
    $rose(init_fault_oe) |-> (init_fault_oe || proc_reset)[*8])
    else $error("fault released too early");
  a_req_to_ack: assert property (
    $rose(irq2_or_ext_request) |-> ##[1:250] irq_ack_oe)
    else $error("request not acknowledged in time");
  a_req_released: assert property (
    $rose(irq_ack_oe) && !ack_second |-> ##[1:4] !irq2_or_ext_request)
    else $error("request kept after acknowledge");
  a_cksum_addr: assert property (
    bus_addr_phase && !irq_ack_oe |->
      bus_addr[31:5] == 27'h0 && bus_addr[1:0] == 2'h0)
    else $error("checksum read outside first eight words");
endmodule

// *** verif/irq_ack_reset_init_tb.sv ***
// Self-checking bench for both ends of the interrupt/reset link.
// Assumes the package, header and interface are compiled first.
`timescale 1ns/1ps
`include "iars_map.svh"
module irq_ack_reset_init_tb;
  import iars_pkg::*;
  logic clock, reset, user_reset_n, strap_primary, strap_init;
  logic raise_request, irq1, cpu_busy, selftest_fail, self_msg, bad_sum;
  logic [7:0] request_vector, vec2_field, vector;
  logic [31:0] mem_rdata, fetch_addr, boot_ptr;
  logic [4:0] cur_priority;
  logic [3:0] irq_clear, irq_pending;
  logic agent_message_pending, service_now, post_vector;
  logic fetch_start, init_enable, halted, late_response;
  iars_role_e role;
  int err_count, checked;
  logic [31:0] mem [8];
  iars_if link ();
  iars_ctrl i_iars_ctrl (.clock(clock), .reset(reset), .link(link),
    .user_reset_n(user_reset_n), .strap_primary(strap_primary),
    .strap_init(strap_init), .raise_request(raise_request),
    .request_vector(request_vector), .irq0_n(1'b1), .irq1(irq1),
    .irq3_n(1'b1), .bad_access(1'b0), .mem_rdata(mem_rdata));
  iars_dev i_iars_dev (.clock(clock), .reset(link.proc_reset),
    .link(link), .vec0_field(8'h10), .vec2_field(vec2_field),
    .cur_priority(cur_priority), .cpu_busy(cpu_busy),
    .selftest_fail(selftest_fail), .self_msg(self_msg),
    .irq_clear(irq_clear), .irq_pending(irq_pending),
    .agent_message_pending(agent_message_pending),
    .service_now(service_now), .post_vector(post_vector),
    .vector(vector), .fetch_start(fetch_start), .fetch_addr(fetch_addr),
    .boot_ptr(boot_ptr), .role(role), .init_enable(init_enable),
    .halted(halted), .late_response(late_response));
  iars_assertions i_iars_assertions (.clock(clock), .reset(reset),
    .proc_reset(link.proc_reset),
    .irq2_or_ext_request(link.irq2_or_ext_request),
    .irq_ack_oe(link.irq_ack_oe), .init_fault_oe(link.init_fault_oe),
    .bus_cycle(link.bus_cycle), .bus_addr_phase(link.bus_addr_phase),
    .bus_addr(link.bus_addr), .bus_ready(link.bus_ready));
  // 50 MHz system clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Boot memory; bad_sum flips bit 0 of every word so the sum no longer wraps to 0
  always @(posedge clock) begin
    mem_rdata <= mem[link.bus_addr[4:2]] ^ {31'h0, bad_sum};
  end
  task print_verdict();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded wait for end of init, or for vector delivery
  task wait_ev(input bit irq);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (n < 900 && !(irq ? (service_now || post_vector)
                                : (fetch_start || halted)));
    if (n >= 900) begin
      err_count++;
      $display("Error at %0t: got %h exp %h", $time, n, 900);
      print_verdict();
    end
  endtask
  task idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Pulses the user reset; late_irq raises line one during self-test
  task boot(input logic prim, init, fail, bad, late_irq);
    @(posedge clock);
    strap_primary <= prim;
    strap_init <= init;
    selftest_fail <= fail;
    bad_sum <= bad;
    user_reset_n <= 1'b0;
    // Long enough for the device reset to clear a stale halt flag
    repeat (6) @(posedge clock);
    user_reset_n <= 1'b1;
    if (late_irq) begin
      repeat (70) @(posedge clock);
      irq1 <= 1'b1;
    end
    wait_ev(1'b0);
  endtask
  task pulse_req(input logic [7:0] v);
    @(posedge clock);
    request_vector <= v;
    raise_request <= 1'b1;
    @(posedge clock);
    raise_request <= 1'b0;
  endtask
  task pulse_clear(input logic [3:0] v);
    @(posedge clock);
    irq_clear <= v;
    @(posedge clock);
    irq_clear <= 4'h0;
    idle(2);
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    user_reset_n = 1'b0;
    {strap_primary, strap_init, raise_request, irq1} = 4'h8;
    {cpu_busy, selftest_fail, self_msg, bad_sum} = 4'h0;
    request_vector = 8'h00;
    vec2_field = 8'h40;
    cur_priority = 5'h00;
    irq_clear = 4'h0;
    mem_rdata = 32'h0;
    mem = '{32'h0000_1000, 32'h0000_0020, 32'h0, 32'h0, 32'h0, 32'h0,
           32'h0, 32'hffff_efe0};
    err_count = 0;
    checked = 0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    // Primary, initializing, line one raised during self-test
    boot(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    chk(32'(halted), 32'h0);
    chk(32'(link.init_fault_n), 32'h1);
    chk(fetch_addr, `IARS_START_ADDR);
    chk(boot_ptr, 32'h0000_1000);
    chk(32'(role), 32'(ROLE_PRIMARY));
    chk(32'(init_enable), 32'h1);
    chk(32'(irq_pending), 32'h0);
    irq1 <= 1'b0;
    $display("test boot primary done");
    // Secondary, no initialization
    boot(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(32'(role), 32'(ROLE_SECONDARY));
    chk(32'(init_enable), 32'h0);
    $display("test boot secondary done");
    // Self-test failure, then bad checksum: both halt with fault held
    for (int i = 0; i < 2; i++) begin
      boot(1'b1, 1'b1, i == 0, i == 1, 1'b0);
      idle(40);
      chk(32'(halted), 32'h1);
      chk(32'(link.init_fault_n), 32'h0);
      chk(32'(link.bus_cycle), 32'h0);
    end
    $display("test halt done");
    // Direct line one, then a self message, each cleared
    boot(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    idle(4);
    @(posedge clock);
    irq1 <= 1'b1;
    idle(8);
    chk(32'(irq_pending[1]), 32'h1);
    pulse_clear(4'h2);
    chk(32'(irq_pending[1]), 32'h0);
    irq1 <= 1'b0;
    @(posedge clock);
    self_msg <= 1'b1;
    @(posedge clock);
    self_msg <= 1'b0;
    idle(2);
    chk(32'(agent_message_pending), 32'h1);
    chk(32'(link.bus_cycle), 32'h0);
    pulse_clear(4'h1);
    chk(32'(agent_message_pending), 32'h0);
    $display("test direct done");
    // Controller mode: held off while busy, then serviced and posted
    vec2_field <= 8'h00;
    cpu_busy <= 1'b1;
    pulse_req(8'h48);
    idle(30);
    chk(32'(link.irq_ack_n), 32'h1);
    cpu_busy <= 1'b0;
    wait_ev(1'b1);
    chk(32'(service_now), 32'h1);
    chk(32'(vector), 32'h48);
    cur_priority <= 5'h1f;
    idle(4);
    pulse_req(8'h30);
    wait_ev(1'b1);
    chk(32'(post_vector), 32'h1);
    chk(32'(vector), 32'h30);
    chk(32'(late_response), 32'h0);
    $display("test controller done");
    print_verdict();
  end
endmodule
